// [core/svrs_consts.svh]
// svrs constants: field positions, reset values and identification codes
`ifndef SVRS_CONSTS_SVH
`define SVRS_CONSTS_SVH

// ****************************************************************
// control/status field positions
// ****************************************************************
`define SVRS_FLAG_LO 0
`define SVRS_FLAG_HI 5
`define SVRS_DNZ_BIT 6
`define SVRS_MASK_LO 7
`define SVRS_MASK_HI 12
`define SVRS_RND_LO 13
`define SVRS_RND_HI 14
`define SVRS_FTZ_BIT 15
`define SVRS_RESV_LO 16
`define SVRS_RESV_HI 31

// ****************************************************************
// reset values
// ****************************************************************
// all six masks set, flush and denormal zeroing off, reserved clear
`define SVRS_CSR_RST 32'h0000_1F80
`define SVRS_VREG_RST 128'h0

// ****************************************************************
// identification
// ****************************************************************
`define SVRS_IDENT_LEAF 32'h0000_0001
`define SVRS_FEAT_BIT 25

// ****************************************************************
// arithmetic flag positions for compare results
// ****************************************************************
`define SVRS_AF_CARRY 0
`define SVRS_AF_PARITY 2
`define SVRS_AF_ZERO 6

`endif

// [core/svrs_pkg.sv]
// svrs package: modes, transfer sizes and request carriers
`default_nettype none
package svrs_pkg;

	typedef enum logic [2:0] {
		SVRS_MODE_REAL = 3'h0,
		SVRS_MODE_V86 = 3'h1,
		SVRS_MODE_PROT = 3'h2,
		SVRS_MODE_COMPAT = 3'h3,
		SVRS_MODE_LONG = 3'h4
	} svrs_mode_t;

	typedef enum logic [1:0] {
		SVRS_XFER_32 = 2'h0,
		SVRS_XFER_64 = 2'h1,
		SVRS_XFER_128 = 2'h2
	} svrs_xfer_t;

	// vector register write (load from memory or execute result)
	typedef struct packed {
		logic valid;
		logic [2:0] reg_num;
		logic ext;
		svrs_xfer_t xfer;
		logic [127:0] data;
	} svrs_wr_t;

	// vector register read or store
	typedef struct packed {
		logic valid;
		logic [2:0] reg_num;
		logic ext;
		svrs_xfer_t xfer;
	} svrs_acc_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} svrs_csr_ld_t;

	typedef struct packed {
		logic valid;
		logic ext;
		logic width_bit;
	} svrs_gpr_t;

	typedef struct packed {
		logic valid;
		logic zero;
		logic parity;
		logic carry;
	} svrs_cmp_t;

	typedef struct packed {
		logic valid;
		logic [31:0] leaf;
	} svrs_ident_t;

endpackage : svrs_pkg
`default_nettype wire

// [core/svrs_reg_dec.sv]
// svrs register number decoder: mode and prefix to physical index
`default_nettype none
module svrs_reg_dec (
	input wire logic [2:0] i_reg_num, // register field of the encoding
	input wire logic i_ext, // extension prefix register bit
	input wire svrs_pkg::svrs_mode_t i_mode, // execution mode
	output logic [3:0] o_idx // physical register index
);
	import svrs_pkg::*;

	wire upper_ok;

	// prefix only reaches the upper bank in 64-bit mode, else ignored
	assign upper_ok = i_ext && (i_mode == SVRS_MODE_LONG);
	assign o_idx = {upper_ok, i_reg_num};

endmodule // svrs_reg_dec
`default_nettype wire

// [core/svrs_state.sv]
// svrs top: vector register file and control/status register state
`default_nettype none
`include "svrs_consts.svh"

module svrs_state (
	input wire logic i_clk, // core clock
	input wire logic i_sys_rst, // async reset, active high
	input wire svrs_pkg::svrs_mode_t i_mode, // execution mode
	input wire svrs_pkg::svrs_wr_t i_wr, // vector register write
	input wire svrs_pkg::svrs_acc_t i_rd, // vector register read
	input wire svrs_pkg::svrs_acc_t i_st, // vector register store
	input wire svrs_pkg::svrs_csr_ld_t i_csr_ld, // control/status load
	input wire logic i_csr_st, // control/status store request
	input wire logic [5:0] i_exc_event, // detected exception conditions
	input wire svrs_pkg::svrs_gpr_t i_gpr, // general register operand
	input wire svrs_pkg::svrs_cmp_t i_cmp, // compare result
	input wire svrs_pkg::svrs_ident_t i_ident, // identification request
	output logic [127:0] o_rd_data, // read data
	output logic o_rd_valid, // read data valid pulse
	output logic [15:0][7:0] o_st_byte, // store bytes, little endian
	output logic [15:0] o_st_byte_en, // store byte enables
	output logic o_st_valid, // store data valid pulse
	output logic [31:0] o_csr, // live control/status value
	output logic [31:0] o_csr_rd, // control/status store data
	output logic o_csr_rd_valid, // store data valid pulse
	output logic o_prot_fault, // protection fault pulse on bad load
	output logic [1:0] o_rnd_ctl, // rounding control field
	output logic o_flush_underflow, // flush-to-zero enable
	output logic o_denorm_zero, // denormal source zeroing enable
	output logic [5:0] o_exc_mask, // per-exception masks
	output logic o_gpr_wide, // 64-bit general register form
	output logic [31:0] o_arith_flags, // compare result flags
	output logic o_arith_wr, // arithmetic flags write pulse
	output logic [31:0] o_feature_flags, // identification feature word
	output logic o_ident_valid // identification answer pulse
);
	import svrs_pkg::*;

	// ****************************************************************
	// storage
	// ****************************************************************
	// private flops, no port from any other register set reaches them
	logic [127:0] vreg_r [16];
	logic [31:0] csr_r;
	logic [31:0] csr_nxt;

	// ****************************************************************
	// register addressing
	// ****************************************************************
	wire [3:0] wr_idx;
	wire [3:0] rd_idx;
	wire [3:0] st_idx;
	wire mode64;

	// only 64-bit mode widens the bank; compatibility, protected,
	// real and virtual-8086 modes all see the same eight registers
	assign mode64 = (i_mode == SVRS_MODE_LONG);

	svrs_reg_dec u_wr_dec (
		.i_reg_num(i_wr.reg_num),
		.i_ext(i_wr.ext),
		.i_mode(i_mode),
		.o_idx(wr_idx)
	);

	svrs_reg_dec u_rd_dec (
		.i_reg_num(i_rd.reg_num),
		.i_ext(i_rd.ext),
		.i_mode(i_mode),
		.o_idx(rd_idx)
	);

	svrs_reg_dec u_st_dec (
		.i_reg_num(i_st.reg_num),
		.i_ext(i_st.ext),
		.i_mode(i_mode),
		.o_idx(st_idx)
	);

	// ****************************************************************
	// write merge
	// ****************************************************************
	wire [127:0] wr_old;
	wire [127:0] wr_merged;

	assign wr_old = vreg_r[wr_idx];
	// narrow writes keep the untouched upper lanes
	assign wr_merged = (i_wr.xfer == SVRS_XFER_32) ?
		{wr_old[127:32], i_wr.data[31:0]} :
		(i_wr.xfer == SVRS_XFER_64) ?
		{wr_old[127:64], i_wr.data[63:0]} : i_wr.data;

	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_vreg
			wire hit;
			assign hit = i_wr.valid && (wr_idx == 4'(g));
			always_ff @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					vreg_r[g] <= `SVRS_VREG_RST;
				end else if (hit) begin
					vreg_r[g] <= wr_merged;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// read and store paths
	// ****************************************************************
	// data leaves only toward execute and memory data; address
	// generation takes general registers and has no tap here
	wire [15:0][7:0] st_byte;
	wire [15:0] st_byte_en;

	svrs_store_fmt u_st_fmt (
		.i_data(vreg_r[st_idx]),
		.i_xfer(i_st.xfer),
		.o_byte(st_byte),
		.o_byte_en(st_byte_en)
	);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rd_data <= 128'h0;
			o_rd_valid <= 1'b0;
			o_st_byte <= '0;
			o_st_byte_en <= 16'h0;
			o_st_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd.valid;
			o_st_valid <= i_st.valid;
			if (i_rd.valid) begin
				o_rd_data <= vreg_r[rd_idx];
			end
			if (i_st.valid) begin
				o_st_byte <= st_byte;
				o_st_byte_en <= st_byte_en;
			end
		end
	end

	// ****************************************************************
	// control/status register
	// ****************************************************************
	wire ld_resv;
	wire ld_ok;
	wire [31:0] csr_base;

	assign ld_resv = i_csr_ld.valid &&
		(|i_csr_ld.data[`SVRS_RESV_HI:`SVRS_RESV_LO]);
	assign ld_ok = i_csr_ld.valid && !ld_resv;
	assign csr_base = ld_ok ? i_csr_ld.data : csr_r;

	// a flag event in the cycle of a clearing load still sets the flag
	always_comb begin
		csr_nxt = csr_base;
		csr_nxt[`SVRS_FLAG_HI:`SVRS_FLAG_LO] =
			csr_base[`SVRS_FLAG_HI:`SVRS_FLAG_LO] | i_exc_event;
		csr_nxt[`SVRS_RESV_HI:`SVRS_RESV_LO] = 16'h0;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			csr_r <= `SVRS_CSR_RST;
			o_prot_fault <= 1'b0;
			o_csr_rd <= 32'h0;
			o_csr_rd_valid <= 1'b0;
		end else begin
			csr_r <= csr_nxt;
			o_prot_fault <= ld_resv;
			o_csr_rd_valid <= i_csr_st;
			if (i_csr_st) begin
				o_csr_rd <= {16'h0, csr_r[`SVRS_RESV_LO-1:0]};
			end
		end
	end

	assign o_csr = csr_r;
	assign o_rnd_ctl = csr_r[`SVRS_RND_HI:`SVRS_RND_LO];
	assign o_flush_underflow = csr_r[`SVRS_FTZ_BIT];
	assign o_denorm_zero = csr_r[`SVRS_DNZ_BIT];
	assign o_exc_mask = csr_r[`SVRS_MASK_HI:`SVRS_MASK_LO];

	// ****************************************************************
	// general register width, compare flags, identification
	// ****************************************************************
	wire gpr_wide_nxt;
	wire [31:0] cmp_flags;
	wire [31:0] feat_word;

	// width bit only counts with a prefix that means something
	assign gpr_wide_nxt = i_gpr.valid && mode64 && i_gpr.ext &&
		i_gpr.width_bit;
	// other arithmetic flags come out cleared
	assign cmp_flags = (32'(i_cmp.carry) << `SVRS_AF_CARRY) |
		(32'(i_cmp.parity) << `SVRS_AF_PARITY) |
		(32'(i_cmp.zero) << `SVRS_AF_ZERO);
	assign feat_word = (i_ident.leaf == `SVRS_IDENT_LEAF) ?
		(32'h1 << `SVRS_FEAT_BIT) : 32'h0;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_gpr_wide <= 1'b0;
			o_arith_flags <= 32'h0;
			o_arith_wr <= 1'b0;
			o_feature_flags <= 32'h0;
			o_ident_valid <= 1'b0;
		end else begin
			o_gpr_wide <= gpr_wide_nxt;
			o_arith_wr <= i_cmp.valid;
			if (i_cmp.valid) begin
				o_arith_flags <= cmp_flags;
			end
			o_ident_valid <= i_ident.valid;
			if (i_ident.valid) begin
				o_feature_flags <= feat_word;
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_ident_feature: assert property (
		i_ident.valid && (i_ident.leaf == `SVRS_IDENT_LEAF)
		|=> o_ident_valid && o_feature_flags[`SVRS_FEAT_BIT]
	) else $error("feature bit not reported for leaf one");

	a_upper_gate: assert property (
		!mode64 |-> !wr_idx[3] && !rd_idx[3] && !st_idx[3]
	) else $error("upper register reached outside 64-bit mode");

	a_upper_reach: assert property (
		mode64 && i_wr.ext |-> wr_idx == {1'b1, i_wr.reg_num}
	) else $error("prefixed write missed upper register");

	a_gpr_width: assert property (
		i_gpr.valid && i_gpr.ext && i_gpr.width_bit
		|=> o_gpr_wide == $past(mode64)
	) else $error("general register width wrong");

	a_scalar_keep: assert property (
		i_wr.valid && (i_wr.xfer == SVRS_XFER_32)
		|=> vreg_r[$past(wr_idx)][127:32] == $past(wr_old[127:32])
		&& vreg_r[$past(wr_idx)][31:0] == $past(i_wr.data[31:0])
	) else $error("scalar write disturbed upper lanes");

	a_store_order: assert property (
		i_st.valid && (i_st.xfer == SVRS_XFER_128)
		|=> o_st_valid && (&o_st_byte_en) && o_st_byte[0] ==
		$past(vreg_r[st_idx][7:0]) && o_st_byte[15] ==
		$past(vreg_r[st_idx][127:120])
	) else $error("store byte order wrong");

	a_resv_fault: assert property (
		ld_resv |=> o_prot_fault
		&& o_csr[15:0] == ($past(csr_r[15:0]) | {10'h0, $past(i_exc_event)})
	) else $error("reserved load not refused");

	a_resv_zero: assert property (
		o_csr[`SVRS_RESV_HI:`SVRS_RESV_LO] == 16'h0
	) else $error("reserved bits nonzero");

	a_flag_sticky: assert property (
		!ld_ok |=> (o_csr[5:0] & $past(o_csr[5:0])) == $past(o_csr[5:0])
	) else $error("sticky flag cleared without load");

	a_flag_set_wins: assert property (
		ld_ok && i_exc_event[0] |=> o_csr[0]
	) else $error("flag event lost to clearing load");

	a_reset_masks: assert property (
		$past(i_sys_rst) |-> o_exc_mask == 6'h3F && !o_flush_underflow
		&& !o_denorm_zero
	) else $error("reset value of control/status wrong");

	a_load_rnd: assert property (
		ld_ok |=> o_rnd_ctl == $past(i_csr_ld.data[14:13])
	) else $error("rounding field not loaded");

	a_store_resv: assert property (
		i_csr_st |=> o_csr_rd_valid && o_csr_rd[31:16] == 16'h0
		&& o_csr_rd[15:0] == $past(csr_r[15:0])
	) else $error("control/status store data wrong");

	a_cmp_flags: assert property (
		i_cmp.valid |=> o_arith_wr && o_arith_flags[6] == $past(i_cmp.zero)
		&& o_arith_flags[0] == $past(i_cmp.carry)
	) else $error("compare flags not recorded");

	a_read_data: assert property (
		i_rd.valid |=> o_rd_valid && o_rd_data == $past(vreg_r[rd_idx])
	) else $error("read data not from addressed register");

	a_store_enable: assert property (
		i_st.valid && (i_st.xfer == SVRS_XFER_32) |=> o_st_byte_en == 16'h000F
	) else $error("scalar store enables wrong");

	a_wide_write: assert property (
		i_wr.valid && (i_wr.xfer == SVRS_XFER_128)
		|=> vreg_r[$past(wr_idx)] == $past(i_wr.data)
	) else $error("full-width write lost");

	a_csr_load: assert property (
		ld_ok |=> !o_prot_fault && o_csr[15:6] == $past(i_csr_ld.data[15:6])
	) else $error("control/status load not applied");

	a_no_fault: assert property (
		!ld_resv |=> !o_prot_fault
	) else $error("fault without reserved load");

	a_narrow_gpr: assert property (
		i_gpr.valid && !mode64 |=> !o_gpr_wide
	) else $error("width bit used outside 64-bit mode");

	a_ident_other: assert property (
		i_ident.valid && (i_ident.leaf != `SVRS_IDENT_LEAF)
		|=> o_ident_valid && o_feature_flags == 32'h0
	) else $error("feature word set for other leaf");

endmodule // svrs_state
`default_nettype wire

// [core/svrs_store_fmt.sv]
// svrs store formatter: register to little-endian memory bytes
`default_nettype none
module svrs_store_fmt (
	input wire logic [127:0] i_data, // register contents
	input wire svrs_pkg::svrs_xfer_t i_xfer, // transfer size
	output logic [15:0][7:0] o_byte, // byte k goes to address base+k
	output logic [15:0] o_byte_en // bytes written to memory
);
	import svrs_pkg::*;

	wire [4:0] n_bytes;

	assign n_bytes = (i_xfer == SVRS_XFER_32) ? 5'h04 :
		(i_xfer == SVRS_XFER_64) ? 5'h08 : 5'h10;

	genvar k;
	generate
		for (k = 0; k < 16; k = k + 1) begin : g_byte
			// low-order register byte lands at the lowest address
			assign o_byte[k] = i_data[8*k +: 8];
			assign o_byte_en[k] = (5'(k) < n_bytes);
		end
	endgenerate

endmodule // svrs_store_fmt
`default_nettype wire

// [tb/svrs_mem_model.sv]
// svrs memory model: sixteen bytes written by store byte enables
`default_nettype none
module svrs_mem_model (
	input wire logic i_clk, // core clock
	input wire logic i_sys_rst, // async reset, active high
	input wire logic i_st_valid, // store data valid pulse
	input wire logic [15:0][7:0] i_byte, // byte k for address base+k
	input wire logic [15:0] i_en, // bytes to write
	output logic [15:0][7:0] o_mem // memory contents, base upward
);
	timeunit 1ns;
	timeprecision 1ps;
	import svrs_pkg::*;
	// non-zero fill so that unwritten bytes never pass for zeros
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_mem <= {16{8'hA5}};
		end else if (i_st_valid) begin
			for (int k = 0; k < 16; k++) begin
				if (i_en[k]) begin
					o_mem[k] <= i_byte[k];
				end
			end
		end
	end
endmodule // svrs_mem_model
`default_nettype wire

// [tb/testbench.sv]
// testbench for the svrs vector register and control/status state
`default_nettype none
`include "svrs_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import svrs_pkg::*;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	svrs_mode_t i_mode = SVRS_MODE_PROT;
	svrs_wr_t i_wr = '0;
	svrs_acc_t i_rd = '0;
	svrs_acc_t i_st = '0;
	svrs_csr_ld_t i_csr_ld = '0;
	logic i_csr_st = 1'b0;
	logic [5:0] i_exc_event = 6'h00;
	svrs_gpr_t i_gpr = '0;
	svrs_cmp_t i_cmp = '0;
	svrs_ident_t i_ident = '0;
	logic [127:0] o_rd_data;
	logic [15:0][7:0] o_st_byte, mem;
	logic [15:0] o_st_byte_en;
	logic [31:0] o_csr, o_csr_rd, o_arith_flags, o_feature_flags;
	logic [1:0] o_rnd_ctl;
	logic [5:0] o_exc_mask;
	logic o_rd_valid, o_st_valid, o_csr_rd_valid, o_prot_fault, o_flush_underflow;
	logic o_denorm_zero, o_gpr_wide, o_arith_wr, o_ident_valid;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [127:0] va = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
	logic [127:0] vb = 128'hFEDCBA98_76543210_89ABCDEF_01234567;

	svrs_state u_svrs_state (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode(i_mode),
		.i_wr(i_wr), .i_rd(i_rd), .i_st(i_st), .i_csr_ld(i_csr_ld), .i_csr_st(i_csr_st),
		.i_exc_event(i_exc_event), .i_gpr(i_gpr), .i_cmp(i_cmp), .i_ident(i_ident),
		.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_st_byte(o_st_byte),
		.o_st_byte_en(o_st_byte_en), .o_st_valid(o_st_valid), .o_csr(o_csr),
		.o_csr_rd(o_csr_rd), .o_csr_rd_valid(o_csr_rd_valid), .o_prot_fault(o_prot_fault),
		.o_rnd_ctl(o_rnd_ctl), .o_flush_underflow(o_flush_underflow),
		.o_denorm_zero(o_denorm_zero), .o_exc_mask(o_exc_mask), .o_gpr_wide(o_gpr_wide),
		.o_arith_flags(o_arith_flags), .o_arith_wr(o_arith_wr),
		.o_feature_flags(o_feature_flags), .o_ident_valid(o_ident_valid));

	svrs_mem_model u_svrs_mem_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_st_valid(o_st_valid), .i_byte(o_st_byte), .i_en(o_st_byte_en), .o_mem(mem));

	// ****************************************************************
	// clock, hang guard, reporting
	// ****************************************************************
	always #4 i_clk = ~i_clk;

	task automatic end_of_test;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// drops every strobe at the taking edge, then lets results settle
	task automatic fin;
		@(posedge i_clk);
		i_wr.valid <= 1'b0;
		i_rd.valid <= 1'b0;
		i_st.valid <= 1'b0;
		i_csr_ld.valid <= 1'b0;
		i_csr_st <= 1'b0;
		i_exc_event <= 6'h00;
		i_gpr.valid <= 1'b0;
		i_cmp.valid <= 1'b0;
		i_ident.valid <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [2:0] n, input logic e, input svrs_xfer_t x,
		input logic [127:0] d);
		@(posedge i_clk);
		i_wr <= '{1'b1, n, e, x, d};
		fin();
	endtask

	task automatic rd_chk(input logic [2:0] n, input logic e, input logic [127:0] exp);
		@(posedge i_clk);
		i_rd <= '{1'b1, n, e, SVRS_XFER_128};
		fin();
		check(o_rd_valid, 1, "read valid");
		check(o_rd_data, exp, "read data");
	endtask

	task automatic st(input logic [2:0] n, input svrs_xfer_t x);
		@(posedge i_clk);
		i_st <= '{1'b1, n, 1'b0, x};
		fin();
	endtask

	task automatic ld(input logic [31:0] d);
		@(posedge i_clk);
		i_csr_ld <= '{1'b1, d};
		fin();
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		check(o_csr, `SVRS_CSR_RST, "csr reset");
		check(o_exc_mask, 6'h3F, "masks reset");
		check({o_flush_underflow, o_denorm_zero}, 2'h0, "modes reset");
	endtask

	task automatic t_ident;
		@(posedge i_clk);
		i_ident <= '{1'b1, `SVRS_IDENT_LEAF};
		fin();
		check(o_ident_valid, 1, "ident valid");
		check(o_feature_flags, 32'h0200_0000, "feature word");
		@(posedge i_clk);
		i_ident <= '{1'b1, 32'h0000_0002};
		fin();
		check(o_ident_valid, 1, "ident valid");
		check(o_feature_flags, 32'h0, "other leaf");
	endtask

	task automatic t_regs;
		svrs_mode_t ml[4] = '{SVRS_MODE_REAL, SVRS_MODE_V86, SVRS_MODE_PROT, SVRS_MODE_COMPAT};
		logic [127:0] d;
		@(posedge i_clk);
		i_mode <= SVRS_MODE_LONG;
		wr(3'h2, 1'b0, SVRS_XFER_128, va);
		wr(3'h2, 1'b1, SVRS_XFER_128, vb);
		rd_chk(3'h2, 1'b0, va);
		rd_chk(3'h2, 1'b1, vb);
		// prefix carries no meaning outside long mode: lands on the low eight
		foreach (ml[i]) begin
			d = va + 128'(i + 1);
			@(posedge i_clk);
			i_mode <= ml[i];
			wr(3'h2, 1'b1, SVRS_XFER_128, d);
			rd_chk(3'h2, 1'b0, d);
			rd_chk(3'h2, 1'b1, d);
		end
		@(posedge i_clk);
		i_mode <= SVRS_MODE_LONG;
		rd_chk(3'h2, 1'b1, vb);
	endtask

	// memory takes the store one edge after the store outputs appear
	task automatic t_xfer;
		logic [127:0] prev;
		wr(3'h1, 1'b0, SVRS_XFER_128, va);
		wr(3'h1, 1'b0, SVRS_XFER_32, vb);
		rd_chk(3'h1, 1'b0, {va[127:32], vb[31:0]});
		wr(3'h1, 1'b0, SVRS_XFER_64, vb);
		rd_chk(3'h1, 1'b0, {va[127:64], vb[63:0]});
		st(3'h1, SVRS_XFER_128);
		check(o_st_valid, 1, "store valid");
		check(o_st_byte_en, 16'hFFFF, "store enables");
		@(posedge i_clk);
		#1;
		check(mem[0], vb[7:0], "lowest byte");
		check(mem, {va[127:64], vb[63:0]}, "store bytes");
		prev = mem;
		wr(3'h1, 1'b0, SVRS_XFER_128, ~va);
		st(3'h1, SVRS_XFER_32);
		check(o_st_valid, 1, "store valid");
		check(o_st_byte_en, 16'h000F, "store enables");
		@(posedge i_clk);
		#1;
		check(mem, {prev[127:32], ~va[31:0]}, "scalar store");
	endtask

	task automatic t_csr;
		ld(32'h0000_6040);
		check(o_csr, 32'h0000_6040, "csr load");
		check(o_rnd_ctl, 2'h3, "rounding");
		check({o_flush_underflow, o_denorm_zero}, 2'h1, "modes");
		check(o_exc_mask, 6'h00, "masks");
		ld(32'h0001_0000);
		check(o_prot_fault, 1, "fault");
		ld(32'h8000_1F80);
		check(o_prot_fault, 1, "fault");
		check(o_csr, 32'h0000_6040, "csr kept");
		@(posedge i_clk);
		i_csr_st <= 1'b1;
		fin();
		check(o_csr_rd_valid, 1, "csr store valid");
		check(o_csr_rd, 32'h0000_6040, "csr store");
		ld(32'h0000_9F80);
		check(o_prot_fault, 0, "no fault");
		check({o_flush_underflow, o_rnd_ctl}, 3'h4, "flush on");
	endtask

	task automatic t_sticky;
		@(posedge i_clk);
		i_exc_event <= 6'h21;
		fin();
		fin();
		fin();
		check(o_csr[5:0], 6'h21, "flags held");
		ld(`SVRS_CSR_RST);
		check(o_csr, `SVRS_CSR_RST, "flags cleared");
		@(posedge i_clk);
		i_exc_event <= 6'h04;
		i_csr_ld <= '{1'b1, `SVRS_CSR_RST};
		fin();
		check(o_csr, 32'h0000_1F84, "event beats clearing load");
		ld(`SVRS_CSR_RST);
	endtask

	task automatic t_gpr_cmp;
		@(posedge i_clk);
		i_gpr <= '{1'b1, 1'b1, 1'b1};
		fin();
		check(o_gpr_wide, 1, "wide form");
		@(posedge i_clk);
		i_gpr <= '{1'b1, 1'b0, 1'b1};
		fin();
		check(o_gpr_wide, 0, "width bit without prefix");
		@(posedge i_clk);
		i_mode <= SVRS_MODE_PROT;
		i_gpr <= '{1'b1, 1'b1, 1'b1};
		fin();
		check(o_gpr_wide, 0, "narrow form");
		@(posedge i_clk);
		i_cmp <= '{1'b1, 1'b1, 1'b0, 1'b1};
		fin();
		check(o_arith_wr, 1, "flags write");
		check(o_arith_flags, 32'h0000_0041, "flags value");
		@(posedge i_clk);
		i_cmp <= '{1'b1, 1'b0, 1'b1, 1'b0};
		fin();
		check(o_arith_wr, 1, "flags write");
		check(o_arith_flags, 32'h0000_0004, "parity flag");
	endtask

	// reset in mid-run must bring back the power-up state
	task automatic t_rerun;
		wr(3'h5, 1'b0, SVRS_XFER_128, vb);
		ld(32'h0000_E07F);
		check(o_csr, 32'h0000_E07F, "csr full load");
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		#1;
		t_reset();
		rd_chk(3'h5, 1'b0, 128'h0);
	endtask

	initial begin
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		#1;
		t_reset();
		t_ident();
		t_regs();
		t_xfer();
		t_csr();
		t_sticky();
		t_gpr_cmp();
		t_rerun();
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
